// ==== common/gpp_pkg.sv ====
// shared constants and types for the two-port pin multiplexer
package gpp_pkg;

   localparam int unsigned PORT_W = 8;

   // register byte offsets
   localparam logic [7:0] OFF_FP_PINS   = 8'h00;
   localparam logic [7:0] OFF_FP_LATCH  = 8'h04;
   localparam logic [7:0] OFF_FP_DIR    = 8'h08;
   localparam logic [7:0] OFF_ANA_CFG   = 8'h0C;
   localparam logic [7:0] OFF_WDT_CTRL  = 8'h10;
   localparam logic [7:0] OFF_SP_PINS   = 8'h14;
   localparam logic [7:0] OFF_SP_LATCH  = 8'h18;
   localparam logic [7:0] OFF_SP_DIR    = 8'h1C;
   localparam logic [7:0] OFF_MEM_CTRL  = 8'h20;
   localparam logic [7:0] OFF_PORT_G    = 8'h24;
   localparam logic [7:0] OFF_MUX_CFG   = 8'h28;

   // field positions
   localparam int unsigned BIT_SHARED_SEL   = 4;  // in watchdog_control
   localparam int unsigned BIT_EXT_BUS_DIS  = 7;  // in memory_bus_control
   localparam int unsigned BIT_PULLUP_EN    = 5;  // in port_g_register
   localparam int unsigned BIT_PAR_MAP      = 0;  // in mux config
   localparam int unsigned BIT_PWM_ALT_MAP  = 1;
   localparam int unsigned BIT_PWM_TRISTATE = 2;
   localparam int unsigned ANA_LSB          = 5;  // channels 13..15 sit in bits 7:5
   localparam int unsigned SPECIAL_LSB      = 5;  // first special pin of first port

   // reset values
   localparam logic [7:0] RST_LATCH    = 8'h00;
   localparam logic [7:0] RST_DIR      = 8'hFF;
   localparam logic [7:0] RST_ANA_CFG  = 8'h00;
   localparam logic [7:0] RST_WDT_CTRL = 8'h00;
   localparam logic [7:0] RST_MEM_CTRL = 8'h80;
   localparam logic [7:0] RST_PORT_G   = 8'h00;
   localparam logic [7:0] RST_MUX_CFG  = 8'h00;

   // pad drive of one 8-bit port; oe_n low means the pin is driven
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_n;
   } gpp_pad_t;

   // strobes offered by the parallel port logic
   typedef struct packed {
      logic master;
      logic wr_strobe;
      logic rd_strobe;
      logic byte_enable;
   } gpp_par_t;

endpackage

// ==== hw/gpp_port_mux.sv ====
// two-port gpio with pin multiplexing, pull-ups and apb register file
//
// Behaviour
// - each pin direction bit 0 drives latch, 1 reads pin as input, unless parallel, pwm or external bus owns the pin
// - second port is 8 bits wide, bidirectional, purely digital
// - any reset leaves all second-port pins as digital inputs
// - external bus enabled forces all second-port pins to bus control outputs
// - each second-port pin has weak pull-up, one shared bit set enables all
// - pull-up of a second-port pin turns off when pin is an output
// - any reset disables the second-port pull-ups
// - parallel map bit 0 puts byte enable on sixth first-port pin
// - same map puts read strobe on seventh pin, out if master, in if slave
// - same map puts write strobe on eighth pin, out if master, in if slave
// - mapped pwm output with direction 0 beats latch and parallel data
// - pwm-mapped pin may go tri-state during pwm shutdown
// - pwm channels reach these pins only while alternate-map bit is clear
// - analog channels 13-15 default analog, digital output still works
// - analog config reachable only while shared select bit is 1
// - small package: port, latch, direction registers read zero
// - analog config bit clear selects analog, set selects digital
`timescale 1ns/1ns
module gpp_port_mux
   import gpp_pkg::*;
#(
   parameter int unsigned ADDR_W    = 12,
   parameter bit          SMALL_PKG = 1'b0
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic [31:0]            prdata,
   // first port pads
   input  wire logic [7:0]        first_port_pin_in,
   output gpp_pad_t               first_port_pad,
   output logic [2:0]             analog_channel_sel,
   // second port pads
   input  wire logic [7:0]        second_port_pin_in,
   output gpp_pad_t               second_port_pad,
   output logic [7:0]             second_port_pullup_on,
   // peripheral sources and sinks
   input  wire gpp_par_t          par_in,
   output logic                   parallel_read_in,
   output logic                   parallel_write_in,
   input  wire logic [2:0]        pwm_out,
   input  wire logic [2:0]        pwm_pin_en,
   input  wire logic              pwm_shutdown,
   input  wire logic [7:0]        ext_bus_ctrl,
   output logic                   ext_bus_enabled
);

   initial begin
      if (ADDR_W < 9 || ADDR_W > 32) begin
         $error("gpp_port_mux: ADDR_W must lie in 9..32");
      end
   end

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a[ADDR_W-1:8] == '0) && (a[7:0] == off);
   endfunction

   // registers
   logic [7:0] fp_latch_r;
   logic [7:0] fp_dir_r;
   logic [7:0] ana_cfg_r;
   logic [7:0] wdt_ctrl_r;
   logic [7:0] sp_latch_r;
   logic [7:0] sp_dir_r;
   logic [7:0] mem_ctrl_r;
   logic [7:0] port_g_r;
   logic [7:0] mux_cfg_r;

   // pin synchronisers; stage one is read only by stage two
   logic [7:0] fp_meta_r;
   logic [7:0] fp_sync_r;
   logic [7:0] sp_meta_r;
   logic [7:0] sp_sync_r;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         fp_meta_r <= 8'h00;
         fp_sync_r <= 8'h00;
         sp_meta_r <= 8'h00;
         sp_sync_r <= 8'h00;
      end else begin
         fp_meta_r <= first_port_pin_in;
         fp_sync_r <= fp_meta_r;
         sp_meta_r <= second_port_pin_in;
         sp_sync_r <= sp_meta_r;
      end
   end

   // apb decode
   wire setup_ph = psel & ~penable;
   wire access   = psel & penable & pready;
   wire do_wr    = access & pwrite;

   wire hit_fp_pins  = hit(paddr, OFF_FP_PINS);
   wire hit_fp_latch = hit(paddr, OFF_FP_LATCH);
   wire hit_fp_dir   = hit(paddr, OFF_FP_DIR);
   wire hit_ana_cfg  = hit(paddr, OFF_ANA_CFG);
   wire hit_wdt      = hit(paddr, OFF_WDT_CTRL);
   wire hit_sp_pins  = hit(paddr, OFF_SP_PINS);
   wire hit_sp_latch = hit(paddr, OFF_SP_LATCH);
   wire hit_sp_dir   = hit(paddr, OFF_SP_DIR);
   wire hit_mem      = hit(paddr, OFF_MEM_CTRL);
   wire hit_port_g   = hit(paddr, OFF_PORT_G);
   wire hit_mux      = hit(paddr, OFF_MUX_CFG);
   wire mapped       = hit_fp_pins | hit_fp_latch | hit_fp_dir | hit_ana_cfg | hit_wdt
                     | hit_sp_pins | hit_sp_latch | hit_sp_dir | hit_mem | hit_port_g
                     | hit_mux;

   wire port_impl  = ~SMALL_PKG;
   wire ana_open   = wdt_ctrl_r[BIT_SHARED_SEL];
   wire [7:0] wbyte = pwdata[7:0];

   // pin level view
   // analog-selected inputs read low so the digital buffer never sees mid-rail
   wire [7:0] ana_mask = {~ana_cfg_r[7:ANA_LSB], 5'h00};
   wire [7:0] fp_level = fp_sync_r & ~ana_mask;
   wire [7:0] sp_level = sp_sync_r;

   wire [7:0] rd_fp_pins  = port_impl ? fp_level   : 8'h00;
   wire [7:0] rd_fp_latch = port_impl ? fp_latch_r : 8'h00;
   wire [7:0] rd_fp_dir   = port_impl ? fp_dir_r   : 8'h00;
   wire [7:0] rd_sp_pins  = port_impl ? sp_level   : 8'h00;
   wire [7:0] rd_sp_latch = port_impl ? sp_latch_r : 8'h00;
   wire [7:0] rd_sp_dir   = port_impl ? sp_dir_r   : 8'h00;
   wire [7:0] rd_ana      = ana_open  ? ana_cfg_r  : 8'h00;

   wire [7:0] rd_byte = hit_fp_pins  ? rd_fp_pins  :
                        hit_fp_latch ? rd_fp_latch :
                        hit_fp_dir   ? rd_fp_dir   :
                        hit_ana_cfg  ? rd_ana      :
                        hit_wdt      ? wdt_ctrl_r  :
                        hit_sp_pins  ? rd_sp_pins  :
                        hit_sp_latch ? rd_sp_latch :
                        hit_sp_dir   ? rd_sp_dir   :
                        hit_mem      ? mem_ctrl_r  :
                        hit_port_g   ? port_g_r    :
                        hit_mux      ? mux_cfg_r   : 8'h00;

   // apb answer: one access cycle, answer registered at setup
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup_ph;
         pslverr_r <= setup_ph & ~mapped;
         prdata_r  <= (setup_ph & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign prdata  = prdata_r;

   // register writes
   wire wr_ok      = do_wr & mapped;
   wire wr_fp_lat  = wr_ok & port_impl & (hit_fp_pins | hit_fp_latch);
   wire wr_sp_lat  = wr_ok & port_impl & (hit_sp_pins | hit_sp_latch);
   wire wr_fp_dir  = wr_ok & port_impl & hit_fp_dir;
   wire wr_sp_dir  = wr_ok & port_impl & hit_sp_dir;
   // closed window: a write to this address is dropped
   wire wr_ana     = wr_ok & hit_ana_cfg & ana_open;
   wire wr_wdt     = wr_ok & hit_wdt;
   wire wr_mem     = wr_ok & hit_mem;
   wire wr_port_g  = wr_ok & hit_port_g;
   wire wr_mux     = wr_ok & hit_mux;

   // first port latch; a pin-register write lands here as well
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         fp_latch_r <= RST_LATCH;
      end else if (wr_fp_lat) begin
         fp_latch_r <= wbyte;
      end
   end

   // first port direction; all ones after reset keeps pins 0..4 inputs, the parallel map still drives pin 5
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         fp_dir_r <= RST_DIR;
      end else if (wr_fp_dir) begin
         fp_dir_r <= wbyte;
      end
   end

   // analog config; reset selects analog on every shared pin
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ana_cfg_r <= RST_ANA_CFG;
      end else if (wr_ana) begin
         ana_cfg_r <= wbyte;
      end
   end

   // shared-register select and the rest of the watchdog byte
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wdt_ctrl_r <= RST_WDT_CTRL;
      end else if (wr_wdt) begin
         wdt_ctrl_r <= wbyte;
      end
   end

   // second port latch; a pin-register write lands here as well
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sp_latch_r <= RST_LATCH;
      end else if (wr_sp_lat) begin
         sp_latch_r <= wbyte;
      end
   end

   // second port direction
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sp_dir_r <= RST_DIR;
      end else if (wr_sp_dir) begin
         sp_dir_r <= wbyte;
      end
   end

   // memory bus control; reset leaves the bus off so the port stays gpio
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         mem_ctrl_r <= RST_MEM_CTRL;
      end else if (wr_mem) begin
         mem_ctrl_r <= wbyte;
      end
   end

   // pull-up enable lives here; reset clears it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         port_g_r <= RST_PORT_G;
      end else if (wr_port_g) begin
         port_g_r <= wbyte;
      end
   end

   // mux config; all clear maps parallel and pwm onto the pins after reset
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         mux_cfg_r <= RST_MUX_CFG;
      end else if (wr_mux) begin
         mux_cfg_r <= wbyte;
      end
   end

   // first port pin drive
   wire par_mapped = ~mux_cfg_r[BIT_PAR_MAP];
   wire pwm_mapped = ~mux_cfg_r[BIT_PWM_ALT_MAP];
   wire pwm_float  = mux_cfg_r[BIT_PWM_TRISTATE] & pwm_shutdown;
   wire [2:0] par_val = {par_in.wr_strobe, par_in.rd_strobe, par_in.byte_enable};
   // byte enable always drives; strobes drive only when the port is master
   wire [2:0] par_drv = {par_in.master, par_in.master, 1'h1};

   logic [7:0] fp_dout;
   logic [7:0] fp_oe_n;

   assign fp_dout[SPECIAL_LSB-1:0] = fp_latch_r[SPECIAL_LSB-1:0];
   assign fp_oe_n[SPECIAL_LSB-1:0] = fp_dir_r[SPECIAL_LSB-1:0];

   genvar k;
   generate
      for (k = 0; k < 3; k++) begin : g_special
         localparam int unsigned P = SPECIAL_LSB + k;
         // pwm needs direction 0 as well as the mapping
         wire pwm_on = pwm_mapped & pwm_pin_en[k] & ~fp_dir_r[P];
         assign fp_dout[P] = pwm_on     ? pwm_out[k] :
                             par_mapped ? par_val[k] : fp_latch_r[P];
         assign fp_oe_n[P] = pwm_on     ? pwm_float  :
                             par_mapped ? ~par_drv[k] : fp_dir_r[P];
      end
   endgenerate

   // second port drive and pull-ups
   wire bus_on = ~mem_ctrl_r[BIT_EXT_BUS_DIS];
   wire [7:0] sp_dout = bus_on ? ext_bus_ctrl : sp_latch_r;
   wire [7:0] sp_oe_n = bus_on ? 8'h00 : sp_dir_r;
   // pull-up only on pins acting as inputs
   wire [7:0] sp_pu = {8{port_g_r[BIT_PULLUP_EN]}} & sp_oe_n;

   // registered pad outputs
   gpp_pad_t   fp_pad_r;
   gpp_pad_t   sp_pad_r;
   logic [7:0] sp_pu_r;
   logic [2:0] ana_sel_r;
   logic       par_rd_r;
   logic       par_wr_r;
   logic       bus_on_r;

   // small package: every pad floats, costs one mux but keeps bonding safe
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         fp_pad_r <= '{dout: RST_LATCH, oe_n: RST_DIR};
      end else begin
         fp_pad_r <= '{dout: fp_dout, oe_n: port_impl ? fp_oe_n : 8'hFF};
      end
   end

   // second port pads; reset leaves every pin an input
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sp_pad_r <= '{dout: RST_LATCH, oe_n: RST_DIR};
      end else begin
         sp_pad_r <= '{dout: sp_dout, oe_n: port_impl ? sp_oe_n : 8'hFF};
      end
   end

   // pull-ups off in reset and on the small package
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sp_pu_r <= 8'h00;
      end else begin
         sp_pu_r <= port_impl ? sp_pu : 8'h00;
      end
   end

   // analog select per channel; never gates the digital drive
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ana_sel_r <= 3'h7;
      end else begin
         ana_sel_r <= ~ana_cfg_r[7:ANA_LSB];
      end
   end

   // slave read strobe from the synchronised pin level
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         par_rd_r <= 1'h0;
      end else begin
         par_rd_r <= par_mapped & ~par_in.master & fp_sync_r[SPECIAL_LSB+1];
      end
   end

   // slave write strobe from the synchronised pin level
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         par_wr_r <= 1'h0;
      end else begin
         par_wr_r <= par_mapped & ~par_in.master & fp_sync_r[SPECIAL_LSB+2];
      end
   end

   // bus state mirrored for the memory controller
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         bus_on_r <= 1'h0;
      end else begin
         bus_on_r <= bus_on;
      end
   end

   assign first_port_pad        = fp_pad_r;
   assign second_port_pad       = sp_pad_r;
   assign second_port_pullup_on = sp_pu_r;
   assign analog_channel_sel    = ana_sel_r;
   assign parallel_read_in      = par_rd_r;
   assign parallel_write_in     = par_wr_r;
   assign ext_bus_enabled       = bus_on_r;

endmodule

// ==== tb/gpp_port_mux_sva.sv ====
// apb and second-port assertions for the pin multiplexer
`timescale 1ns/1ns
module gpp_port_mux_sva
   import gpp_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic              mclk,
   input wire logic              rstn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [31:0]       prdata,
   input wire gpp_pad_t          second_port_pad,
   input wire logic [7:0]        second_port_pullup_on,
   input wire logic [7:0]        ext_bus_ctrl,
   input wire logic              ext_bus_enabled
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_cause: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_map: assert property (pready |-> pslverr == (|paddr[ADDR_W-1:8] || paddr[1:0] != 2'h0
      || paddr[7:0] > OFF_MUX_CFG)) else $error("pslverr wrong for address");
   a_rdata_zero: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h00000000)
      else $error("prdata not zero");
   a_bus_takes: assert property (ext_bus_enabled && $past(ext_bus_enabled) |->
      second_port_pad.oe_n == 8'h00 && second_port_pad.dout == $past(ext_bus_ctrl))
      else $error("bus does not own second port");
   a_pull_out: assert property ((second_port_pullup_on & ~second_port_pad.oe_n) == 8'h00)
      else $error("pull-up on driven pin");
   a_reset_state: assert property (disable iff (1'h0) !rstn |=> second_port_pad.oe_n == 8'hFF
      && second_port_pullup_on == 8'h00 && !ext_bus_enabled) else $error("reset state wrong");
endmodule
bind gpp_port_mux gpp_port_mux_sva #(.ADDR_W(ADDR_W)) gpp_port_mux_sva_inst (.mclk, .rstn,
   .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata, .second_port_pad,
   .second_port_pullup_on, .ext_bus_ctrl, .ext_bus_enabled);

// ==== tb/gpp_pin_model.sv ====
// external circuitry on one port: drivers, pull-ups, floating pins
`timescale 1ns/1ns
module gpp_pin_model
   import gpp_pkg::*;
(
   input  wire logic       mclk,
   input  wire gpp_pad_t   pad,
   input  wire logic [7:0] pull,
   input  wire logic [7:0] ext_v,
   input  wire logic [7:0] ext_en,
   output logic [7:0]      pin
);
   logic [7:0] last_r = 8'h00;
   // floating bits toggle so a stale level never passes as valid
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pad.oe_n[i])
            pin[i] = pad.dout[i];
         else if (ext_en[i])
            pin[i] = ext_v[i];
         else
            pin[i] = pull[i] | ~last_r[i];
      end
   end
   always_ff @(posedge mclk) last_r <= pin;
endmodule

// ==== tb/gpp_port_mux_bench.sv ====
// self-checking bench for the two-port pin multiplexer
`timescale 1ns/1ns
module gpp_port_mux_bench
   import gpp_pkg::*;
;
   logic        mclk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdat;
   logic        pready, pslverr, rerr, prd_in, pwr_in, ebe, pwm_sd = 1'h0;
   logic [7:0]  pin1, pin2, pull2, ebc = 8'h00, x1 = 8'h00, x2 = 8'h00;
   logic [2:0]  asel, pwm = 3'h0, pen = 3'h0;
   gpp_pad_t    pad1, pad2;
   gpp_par_t    par = 4'h0;
   logic [7:0]  sh [0:10];
   int          error_cnt = 0, total_checks = 0, cyc = 0;
   always #50 mclk = ~mclk;
   gpp_port_mux #(.ADDR_W(12), .SMALL_PKG(1'h0)) gpp_port_mux_inst (.mclk, .rstn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .first_port_pin_in(pin1),
      .first_port_pad(pad1), .analog_channel_sel(asel), .second_port_pin_in(pin2),
      .second_port_pad(pad2), .second_port_pullup_on(pull2), .par_in(par),
      .parallel_read_in(prd_in), .parallel_write_in(pwr_in), .pwm_out(pwm), .pwm_pin_en(pen),
      .pwm_shutdown(pwm_sd), .ext_bus_ctrl(ebc), .ext_bus_enabled(ebe));
   gpp_pin_model gpp_pin_model_inst_a (.mclk, .pad(pad1), .pull(8'h00), .ext_v(x1),
      .ext_en(8'hFF), .pin(pin1));
   gpp_pin_model gpp_pin_model_inst_b (.mclk, .pad(pad2), .pull(pull2), .ext_v(x2),
      .ext_en(8'hFF), .pin(pin2));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'($urandom()), d};
      @(posedge mclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      chk("pready", 16'h1, 16'(pready));
   endtask
   // model of the first port pad, pins 5..7 muxed
   function automatic gpp_pad_t fpad();
      gpp_pad_t p;
      p = {sh[1], sh[2]};
      for (int k = 0; k < 3; k++) begin
         if (!sh[10][1] && pen[k] && !sh[2][5+k]) begin
            p.dout[5+k] = pwm[k];
            p.oe_n[5+k] = sh[10][2] & pwm_sd;
         end else if (!sh[10][0]) begin
            p.dout[5+k] = k == 0 ? par.byte_enable : k == 1 ? par.rd_strobe : par.wr_strobe;
            p.oe_n[5+k] = k == 0 ? 1'h0 : ~par.master;
         end
      end
      return p;
   endfunction
   function automatic gpp_pad_t spad();
      return sh[8][7] ? {sh[6], sh[7]} : {ebc, 8'h00};
   endfunction
   function automatic logic [7:0] rexp(input int i);
      gpp_pad_t p;
      p = i == 0 ? fpad() : spad();
      if (i == 0 || i == 5)
         return ((p.dout & ~p.oe_n) | ((i == 0 ? x1 : x2) & p.oe_n))
            & (i == 0 ? {sh[3][7:5], 5'h1F} : 8'hFF);
      return (i != 3 || sh[4][4]) ? sh[i] : 8'h00;
   endfunction
   task automatic wr(input int i, input logic [7:0] d);
      apb(1'h1, 12'(i * 4), d);
      if (i == 0 || i == 5)
         sh[i+1] = d;
      else if (i != 3 || sh[4][4])
         sh[i] = d;
   endtask
   task automatic chk_all(input string tn);
      gpp_pad_t sp;
      repeat (4) @(posedge mclk);
      #1;
      sp = spad();
      chk("fp_pad", fpad(), pad1);
      chk("sp_pad", sp, pad2);
      chk("pullup", 16'({8{sh[9][5]}} & sp.oe_n), 16'(pull2));
      chk("ana_sel", {13'h0000, ~sh[3][7:5]}, 16'(asel));
      chk("bus_en", 16'(!sh[8][7]), 16'(ebe));
      chk("par_in", 16'({2{!sh[10][0] && !par.master}} & {pin1[6], pin1[7]}),
          16'({prd_in, pwr_in}));
      for (int i = 0; i < 11; i++) begin
         apb(1'h0, 12'(i * 4), 8'h00);
         chk("reg", 16'(rexp(i)), 16'(rdat[7:0]));
      end
      $display("test %s done", tn);
   endtask
   initial begin
      void'($urandom(17711));
      x1 = 8'($urandom());
      x2 = 8'($urandom());
      ebc = 8'($urandom());
      sh = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h80, 8'h00, 8'h00};
      repeat (16) @(posedge mclk);
      rstn <= 1'h1;
      chk_all("reset");
      apb(1'h0, 12'h02C, 8'h00);
      chk("unmapped", 16'h1, 16'(rerr));
      apb(1'h1, 12'h104, 8'hFF);
      chk("unmapped", 16'h1, 16'(rerr));
      wr(10, 8'h01);
      wr(0, 8'($urandom()));
      wr(2, 8'($urandom()));
      wr(3, 8'hE0);
      wr(4, 8'h10);
      wr(3, 8'hA0);
      wr(4, 8'h00);
      chk_all("first_port");
      wr(5, 8'($urandom()));
      wr(7, 8'($urandom()));
      wr(9, 8'h20);
      chk_all("second_port");
      wr(8, 8'h00);
      chk_all("ext_bus");
      wr(8, 8'h80);
      // every mux config, random peripheral traffic
      for (int m = 0; m < 8; m++) begin
         wr(10, 8'(m));
         wr(2, {3'($urandom()), 5'h1F});
         @(posedge mclk);
         par <= 4'($urandom());
         pwm <= 3'($urandom());
         pen <= 3'($urandom());
         pwm_sd <= 1'($urandom());
         x1 <= 8'($urandom());
         chk_all("mux");
      end
      rstn <= 1'h0;
      repeat (2) @(posedge mclk);
      rstn <= 1'h1;
      sh = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h80, 8'h00, 8'h00};
      chk_all("second_reset");
      close_out();
   end
endmodule
